// file: logic/tccc_ctrl.sv
// What this block does
// - Command field bits 7:5: 0 none, 1 retrigger, 2 stop.
// - Command 3 forces update of buffered registers, 4 forces value read sync.
// - Commands execute on next prescaled timer clock tick, not on the write.
// - Command field reads zero once the command has executed.
// - Clear register command write: zero ignored, any one cancels pending command.
// - Ramp index command acts only in either dual-slope ramp mode.
// - Index command: 0 toggle, 1 force B, 2 force A, 3 repeat.
// - Index command applied at update condition; flag updates, field clears.
// - Index field zero write ignored; ones via clear register cancel it.
// - Single-run stops counter at next wrap or on stop command.
// - Without single-run, counter reloads on wrap and keeps running.
// - Writing one to single-run bit via clear register disables it.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module tccc_ctrl
(
  input  wire  logic                  core_clk_i,
  input  wire  logic                  arst_n_i,
  input  wire  logic                  psel_i,
  input  wire  logic                  penable_i,
  input  wire  logic                  pwrite_i,
  input  wire  logic [7:0]            paddr_i,
  input  wire  logic [31:0]           pwdata_i,
  output logic                        pready_o,
  output logic                        pslverr_o,
  output logic [31:0]                 prdata_o,
  input  wire  logic                  presc_tick_i,
  input  wire  logic                  wrap_i,
  input  wire  logic                  update_cond_i,
  input  wire  logic                  dual_slope_i,
  output tccc_pkg::tccc_strobe_t      strobe_o,
  output logic                        running_o,
  output logic                        cycle_select_flag_o,
  output logic                        single_run_o,
  output logic                        lock_update_o,
  output logic                        direction_o
);

  // ==========================================================================
  // Bus decode
  logic       wr_en;
  logic       rd_en;
  logic       hit_clr;
  logic       hit_set;
  logic       hit_sts;
  logic [7:0] wbyte;

  assign wr_en   = psel_i && penable_i && pwrite_i;
  assign rd_en   = psel_i && penable_i && !pwrite_i;
  assign hit_clr = (paddr_i == tccc_pkg::CLEAR_OFFSET);
  assign hit_set = (paddr_i == tccc_pkg::SET_OFFSET);
  assign hit_sts = (paddr_i == tccc_pkg::STATUS_OFFSET);
  assign wbyte   = pwdata_i[7:0];

  logic [2:0] cmd_reg;
  logic [1:0] idx_reg;
  logic       single_reg;
  logic       lock_reg;
  logic       dir_reg;
  logic       flag_reg;
  tccc_pkg::tccc_state_t state_reg;

  logic cmd_clr;
  logic idx_clr;
  logic cmd_exec;

  assign cmd_clr  = wr_en && hit_clr && (wbyte[tccc_pkg::CMD_MSB:tccc_pkg::CMD_LSB] != 3'h0);
  assign idx_clr  = wr_en && hit_clr && (wbyte[tccc_pkg::IDX_MSB:tccc_pkg::IDX_LSB] != 2'h0);
  assign cmd_exec = presc_tick_i && (cmd_reg != 3'h0);

  // ==========================================================================
  // Bus answer: zero wait states, unmapped addresses error
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !(hit_clr || hit_set || hit_sts);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
    end
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      if (hit_clr || hit_set)
      begin
        prdata_o <= {24'h00_0000, cmd_reg, idx_reg, single_reg, lock_reg, dir_reg};
      end
      else if (hit_sts)
      begin
        prdata_o <= {30'h0000_0000, flag_reg, (state_reg == tccc_pkg::TCCC_ST_RUN)};
      end
      else
      begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Command field
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_reg <= tccc_pkg::CLEAR_RESET[tccc_pkg::CMD_MSB:tccc_pkg::CMD_LSB];
    end
    else if (cmd_clr)
    begin
      cmd_reg <= 3'h0;
    end
    else if (wr_en && hit_set && (wbyte[tccc_pkg::CMD_MSB:tccc_pkg::CMD_LSB] != 3'h0))
    begin
      cmd_reg <= wbyte[tccc_pkg::CMD_MSB:tccc_pkg::CMD_LSB];
    end
    else if (cmd_exec)
    begin
      cmd_reg <= 3'h0;
    end
  end

  // Command strobes on the prescaled tick
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strobe_o <= '0;
    end
    else
    begin
      strobe_o.retrigger       <= cmd_exec && !cmd_clr
                                  && (cmd_reg == tccc_pkg::TCCC_CMD_RETRG);
      strobe_o.stop            <= cmd_exec && !cmd_clr
                                  && (cmd_reg == tccc_pkg::TCCC_CMD_STOP);
      strobe_o.force_update    <= cmd_exec && !cmd_clr
                                  && (cmd_reg == tccc_pkg::TCCC_CMD_UPD);
      strobe_o.value_read_sync <= cmd_exec && !cmd_clr
                                  && (cmd_reg == tccc_pkg::TCCC_CMD_RSYNC);
    end
  end

  // ==========================================================================
  // Ramp index command and flag
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idx_reg <= tccc_pkg::CLEAR_RESET[tccc_pkg::IDX_MSB:tccc_pkg::IDX_LSB];
    end
    else if (idx_clr)
    begin
      idx_reg <= 2'h0;
    end
    else if (wr_en && hit_set && (wbyte[tccc_pkg::IDX_MSB:tccc_pkg::IDX_LSB] != 2'h0))
    begin
      idx_reg <= wbyte[tccc_pkg::IDX_MSB:tccc_pkg::IDX_LSB];
    end
    else if (update_cond_i && dual_slope_i)
    begin
      idx_reg <= 2'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_reg <= 1'b0;
    end
    else if (update_cond_i && dual_slope_i)
    begin
      // A cancel in the same cycle falls back to plain toggling
      case (idx_clr ? 2'h0 : idx_reg)
        tccc_pkg::TCCC_IDX_TOGGLE: flag_reg <= !flag_reg;
        tccc_pkg::TCCC_IDX_SET:    flag_reg <= 1'b1;
        tccc_pkg::TCCC_IDX_CLEAR:  flag_reg <= 1'b0;
        tccc_pkg::TCCC_IDX_HOLD:   flag_reg <= flag_reg;
        default:                   flag_reg <= flag_reg;
      endcase
    end
  end

  // ==========================================================================
  // Single-run, lock-update, direction bits
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      single_reg <= tccc_pkg::CLEAR_RESET[tccc_pkg::SINGLE_POS];
    end
    else if (wr_en && hit_clr && wbyte[tccc_pkg::SINGLE_POS])
    begin
      single_reg <= 1'b0;
    end
    else if (wr_en && hit_set && wbyte[tccc_pkg::SINGLE_POS])
    begin
      single_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_reg <= tccc_pkg::CLEAR_RESET[tccc_pkg::LOCK_POS];
    end
    else if (wr_en && hit_clr && wbyte[tccc_pkg::LOCK_POS])
    begin
      lock_reg <= 1'b0;
    end
    else if (wr_en && hit_set && wbyte[tccc_pkg::LOCK_POS])
    begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dir_reg <= tccc_pkg::CLEAR_RESET[tccc_pkg::DIR_POS];
    end
    else if (wr_en && hit_clr && wbyte[tccc_pkg::DIR_POS])
    begin
      dir_reg <= 1'b0;
    end
    else if (wr_en && hit_set && wbyte[tccc_pkg::DIR_POS])
    begin
      dir_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Run state
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= tccc_pkg::TCCC_ST_STOP;
    end
    else
    begin
      case (state_reg)
        tccc_pkg::TCCC_ST_RUN:
        begin
          if (strobe_o.stop)
          begin
            state_reg <= tccc_pkg::TCCC_ST_STOP;
          end
          else if (wrap_i && single_reg)
          begin
            state_reg <= tccc_pkg::TCCC_ST_STOP;
          end
          else
          begin
            state_reg <= tccc_pkg::TCCC_ST_RUN;
          end
        end
        tccc_pkg::TCCC_ST_STOP:
        begin
          if (strobe_o.retrigger)
          begin
            state_reg <= tccc_pkg::TCCC_ST_RUN;
          end
        end
        default:
        begin
          state_reg <= tccc_pkg::TCCC_ST_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      running_o <= 1'b0;
    end
    else
    begin
      running_o <= (state_reg == tccc_pkg::TCCC_ST_RUN);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cycle_select_flag_o <= 1'b0;
    end
    else
    begin
      cycle_select_flag_o <= flag_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      single_run_o <= 1'b0;
    end
    else
    begin
      single_run_o <= single_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_update_o <= 1'b0;
    end
    else
    begin
      lock_update_o <= lock_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      direction_o <= 1'b0;
    end
    else
    begin
      direction_o <= dir_reg;
    end
  end

endmodule

`default_nettype wire

// file: logic/tccc_pkg.sv
`default_nettype none

package tccc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CLEAR_OFFSET  = 8'h04;
  localparam logic [7:0] SET_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] CLEAR_RESET   = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CMD_MSB    = 7;
  localparam int CMD_LSB    = 5;
  localparam int IDX_MSB    = 4;
  localparam int IDX_LSB    = 3;
  localparam int SINGLE_POS = 2;
  localparam int LOCK_POS   = 1;
  localparam int DIR_POS    = 0;

  // ==========================================================================
  // Commands
  typedef enum logic [2:0] {
    TCCC_CMD_NONE  = 3'b000,
    TCCC_CMD_RETRG = 3'b001,
    TCCC_CMD_STOP  = 3'b010,
    TCCC_CMD_UPD   = 3'b011,
    TCCC_CMD_RSYNC = 3'b100
  } tccc_cmd_t;

  typedef enum logic [1:0] {
    TCCC_IDX_TOGGLE = 2'b00,
    TCCC_IDX_SET    = 2'b01,
    TCCC_IDX_CLEAR  = 2'b10,
    TCCC_IDX_HOLD   = 2'b11
  } tccc_idx_t;

  typedef enum logic [1:0] {
    TCCC_ST_RUN  = 2'b00,
    TCCC_ST_STOP = 2'b01
  } tccc_state_t;

  // Strobes toward the counter core
  typedef struct packed {
    logic retrigger;
    logic stop;
    logic force_update;
    logic value_read_sync;
  } tccc_strobe_t;

endpackage

`default_nettype wire

// file: verif/tccc_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module tccc_ctrl_assertions
(
  input  wire logic                   core_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic                   pready_o,
  input  wire logic                   pslverr_o,
  input  wire logic                   presc_tick_i,
  input  wire logic                   wrap_i,
  input  wire logic                   update_cond_i,
  input  wire tccc_pkg::tccc_strobe_t strobe_o,
  input  wire logic                   running_o,
  input  wire logic                   single_run_o,
  input  wire logic                   cycle_select_flag_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==========================================================================
  // Bus phases
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_unmapped;
    s_setup ##0 !(paddr_i inside {8'h04, 8'h08, 8'h0C});
  endsequence

  a_pready_timely: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  a_unmapped_err: assert property (s_unmapped |=> pslverr_o)
    else $error("unmapped access not flagged");
  a_strobe_single: assert property ($onehot0(strobe_o))
    else $error("several command strobes at once");
  a_strobe_pulse: assert property (|strobe_o |=> !(|strobe_o))
    else $error("strobe longer than one cycle");
  a_strobe_tick: assert property (|strobe_o |->
    $past(presc_tick_i) || $past(presc_tick_i, 2))
    else $error("strobe without timer tick");
  a_stop_halts: assert property (strobe_o.stop |-> ##[1:4] !running_o)
    else $error("stop did not halt");
  a_retrig_runs: assert property (strobe_o.retrigger |-> ##[1:4] running_o)
    else $error("retrigger did not start");
  a_single_wrap: assert property (single_run_o && running_o && wrap_i |->
    ##[1:4] !running_o)
    else $error("single run kept counting");
  a_flag_update: assert property ($changed(cycle_select_flag_o) |->
    $past(update_cond_i) || $past(update_cond_i, 2))
    else $error("index flag moved without update");
endmodule

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic core_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic presc_tick_i = 0, wrap_i = 0, update_cond_i = 0, dual_slope_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, running_o, cycle_select_flag_o;
  logic single_run_o, lock_update_o, direction_o, err;
  tccc_pkg::tccc_strobe_t strobe_o, seen;
  int n_fail = 0, num_checks = 0, cyc = 0;

  always #2 core_clk_i = ~core_clk_i;

  tccc_ctrl DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .presc_tick_i(presc_tick_i), .wrap_i(wrap_i), .update_cond_i(update_cond_i),
    .dual_slope_i(dual_slope_i), .strobe_o(strobe_o), .running_o(running_o),
    .cycle_select_flag_o(cycle_select_flag_o), .single_run_o(single_run_o),
    .lock_update_o(lock_update_o), .direction_o(direction_o));

  // ==========================================================================
  // Shared tasks
  task test_done;
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Pulse 0 tick, 1 wrap, 2 update; collect strobes meanwhile
  task pulse(input int k);
    seen = '0;
    @(posedge core_clk_i);
    {presc_tick_i, wrap_i, update_cond_i} <= {k == 0, k == 1, k == 2};
    repeat (6)
    begin
      @(posedge core_clk_i);
      seen = seen | strobe_o;
      {presc_tick_i, wrap_i, update_cond_i} <= 3'b000;
    end
  endtask

  // ==========================================================================
  // Scenarios
  task t_reset;
    apb(1'b0, 8'h04, 8'h00);
    chk("clear_reset", rd, 32'h0);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped_err", err, 32'h1);
  endtask

  task t_cmds;
    for (int c = 1; c <= 4; c++)
    begin
      apb(1'b1, 8'h08, 8'(c << 5));
      apb(1'b0, 8'h04, 8'h00);
      chk("cmd_pending", rd[7:5], c);
      pulse(0);
      chk("strobe", seen, 4'b1000 >> (c - 1));
      chk("running", running_o, c == 1);
      apb(1'b0, 8'h04, 8'h00);
      chk("cmd_done", rd[7:5], 32'h0);
    end
  endtask

  task t_cancel;
    apb(1'b1, 8'h08, 8'h20);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b0, 8'h04, 8'h00);
    chk("cmd_kept", rd[7:5], 32'h1);
    apb(1'b1, 8'h04, 8'h80);
    pulse(0);
    chk("cmd_cancel", seen, 32'h0);
    apb(1'b1, 8'h08, 8'h08);
    apb(1'b1, 8'h04, 8'h10);
    apb(1'b0, 8'h04, 8'h00);
    chk("idx_cancel", rd[4:3], 32'h0);
  endtask

  task t_index;
    logic [1:0] code [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic       flag [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    apb(1'b1, 8'h08, 8'h10);
    pulse(2);
    apb(1'b0, 8'h04, 8'h00);
    chk("idx_idle", rd[4:3], 32'h2);
    @(posedge core_clk_i);
    dual_slope_i <= 1'b1;
    pulse(2);
    apb(1'b0, 8'h04, 8'h00);
    chk("idx_applied", rd[4:3], 32'h0);
    chk("idx_flag", cycle_select_flag_o, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      if (code[i] != 2'h0)
        apb(1'b1, 8'h08, {3'h0, code[i], 3'h0});
      pulse(2);
      chk("idx_code", cycle_select_flag_o, flag[i]);
    end
  endtask

  task t_single;
    apb(1'b1, 8'h08, 8'h27);
    apb(1'b0, 8'h04, 8'h00);
    chk("bits_read", rd[2:0], 32'h7);
    pulse(0);
    pulse(1);
    chk("single_stop", running_o, 32'h0);
    apb(1'b1, 8'h04, 8'h06);
    repeat (2) @(posedge core_clk_i);
    chk("single_off", {single_run_o, lock_update_o, direction_o}, 32'h1);
    apb(1'b1, 8'h08, 8'h20);
    pulse(0);
    pulse(1);
    chk("reload_run", running_o, 32'h1);
    apb(1'b0, 8'h0C, 8'h00);
    chk("status", rd[1:0], 32'h3);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_cmds;
    t_cancel;
    t_index;
    t_single;
    test_done;
  end

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end
endmodule

bind tccc_ctrl tccc_ctrl_assertions u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .presc_tick_i(presc_tick_i), .wrap_i(wrap_i),
  .update_cond_i(update_cond_i), .strobe_o(strobe_o), .running_o(running_o),
  .single_run_o(single_run_o), .cycle_select_flag_o(cycle_select_flag_o));

`default_nettype wire
